// ### rtl/pmd_pkg.sv
// Summary of operation
// RULE1: signed-unsigned mac adds 32-bit product
// RULE2: first source signed, second source unsigned
// RULE3: mac takes two cycles, one word
// RULE4: short move reaches lowest 64 words
// RULE5: register, memory and immediate moves supported
// RULE6: conditional transfer writes only when true
// RULE7: dual move-only read does no arithmetic
// RULE8: parallel move is single or dual read
// RULE9: parallel move only beside arithmetic ops
// RULE10: peripherals reached as data memory words
// RULE11: full accumulator to 16 bits saturates
// RULE12: accumulator word portion source never saturates
// RULE13: saturation sets sticky limit flag
// RULE14: load into accumulator sign-extends, zeroes low
// RULE15: high-word destination alters only that word
// RULE16: parallel move post-increments by one or offset
// RULE17: seventeen alu ops accept single parallel move
// RULE18: alu source may feed the parallel move
// RULE19: stream never doubles the alu destination
// RULE20: test and compare allow accumulator destination; the code still rejects the high-word destination
// RULE21: duplicate destination rejected, not executed
package pmd_pkg;
  localparam int PMD_ACC_W = 36;
  localparam int PMD_WORD_W = 16;
  localparam int PMD_ADDR_W = 16;
  localparam int PMD_SHORT_WORDS = 64;
  localparam int PMD_MAC_CYCLES = 2;
  localparam logic [15:0] PMD_SAT_POS = 16'h7FFF;
  localparam logic [15:0] PMD_SAT_NEG = 16'h8000;
  localparam logic [15:0] PMD_RST_WORD = 16'h0000;
  localparam logic [35:0] PMD_RST_ACC = 36'h000000000;

  typedef enum logic [4:0] {
    PMD_OP_NONE = 5'h00, PMD_OP_ADD = 5'h01, PMD_OP_SUB = 5'h02,
    PMD_OP_CMP = 5'h03, PMD_OP_TFR = 5'h04, PMD_OP_MAC = 5'h05,
    PMD_OP_MPY = 5'h06, PMD_OP_MACR = 5'h07, PMD_OP_MPYR = 5'h08,
    PMD_OP_ABS = 5'h09, PMD_OP_ASL = 5'h0A, PMD_OP_ASR = 5'h0B,
    PMD_OP_CLR = 5'h0C, PMD_OP_RND = 5'h0D, PMD_OP_TST = 5'h0E,
    PMD_OP_INC = 5'h0F, PMD_OP_DEC = 5'h10, PMD_OP_NEG = 5'h11,
    PMD_OP_SUMAC = 5'h12, PMD_OP_JUMP = 5'h13, PMD_OP_LEA = 5'h14,
    PMD_OP_BIT_FIELD_SET_OP = 5'h15, PMD_OP_MOVE = 5'h16, PMD_OP_COND = 5'h17
  } pmd_op_t;

  // register names for move operands
  typedef enum logic [3:0] {
    PMD_R_X0 = 4'h0, PMD_R_Y0 = 4'h1, PMD_R_Y1 = 4'h2,
    PMD_R_A = 4'h3, PMD_R_B = 4'h4, PMD_R_A1 = 4'h5,
    PMD_R_B1 = 4'h6, PMD_R_A0 = 4'h7, PMD_R_B0 = 4'h8,
    PMD_R_NONE = 4'hF
  } pmd_reg_t;

  typedef enum logic [2:0] {
    PMD_MV_NONE = 3'h0, PMD_MV_SINGLE = 3'h1, PMD_MV_DUAL = 3'h2,
    PMD_MV_REG = 3'h3, PMD_MV_IMM = 3'h4, PMD_MV_SHORT = 3'h5
  } pmd_mv_t;

  typedef struct packed {
    pmd_op_t op;
    pmd_reg_t src1;
    pmd_reg_t src2;
    logic dst_b;
    pmd_mv_t mv;
    pmd_reg_t mv_reg;
    logic mv_write;
    logic mv_by_off;
    logic cond_true;
    logic [15:0] imm;
    logic [5:0] short_addr;
  } pmd_instr_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pmd_mem_t;
endpackage

// ### rtl/pmd_mac.sv
`timescale 1ns/1ps
module pmd_mac
  import pmd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [15:0] s1,
  input wire logic [15:0] s2,
  input wire logic [35:0] acc_in,
  output logic done,
  output logic [35:0] acc_out
);
  logic [31:0] prod_reg;
  logic busy_reg;
  logic done_reg;
  logic [35:0] sum_reg;
  wire signed [32:0] prod_full;
  wire [32:0] prod_shift;
  // ----------------------------------------
  // signed by unsigned product
  // ----------------------------------------
  // RULE2: s1 signed s2 unsigned
  assign prod_full = $signed(s1) * $signed({1'b0, s2});
  // RULE1: fractional 32-bit product
  assign prod_shift = {prod_full[31:0], 1'b0};
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prod_reg <= 32'h00000000;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      sum_reg <= PMD_RST_ACC;
    end else begin
      busy_reg <= start;
      done_reg <= busy_reg;
      if (start) begin
        prod_reg <= prod_shift[31:0];
      end
      // RULE1: accumulate with sign extension
      if (busy_reg) begin
        sum_reg <= acc_in + {{4{prod_reg[31]}}, prod_reg};
      end
    end
  end
  // RULE3: result after two cycles
  assign done = done_reg;
  assign acc_out = sum_reg;

  a_mac_two_cycles: assert property (@(posedge core_clk) disable iff (rst)
    start |-> ##2 done) else $error("mac not done in two cycles"); // RULE3
endmodule // pmd_mac

// ### rtl/pmd_core.sv
`timescale 1ns/1ps
module pmd_core
  import pmd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire pmd_instr_t instr,
  input wire logic [15:0] mem_rdata,
  input wire logic [15:0] mem_rdata2,
  input wire logic limit_clear,
  output pmd_mem_t mem_req,
  output logic [15:0] ptr_addr,
  output logic ready,
  output logic illegal,
  output logic limit_flag,
  output logic [35:0] acc_a,
  output logic [35:0] acc_b,
  output logic [15:0] x0,
  output logic [15:0] y0,
  output logic [15:0] y1
);
  typedef enum logic [1:0] {
    PMD_S_IDLE = 2'b00, PMD_S_MAC = 2'b01, PMD_S_DONE = 2'b10
  } pmd_state_t;

  pmd_state_t state_reg, state_next;
  logic [35:0] a_reg, b_reg;
  logic [15:0] x0_reg, y0_reg, y1_reg;
  logic [15:0] ptr_reg, off_reg;
  logic lim_reg, ill_reg;
  pmd_mem_t mem_reg;
  logic mac_b_reg;
  logic mac_done;
  logic [35:0] mac_out;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic [15:0] rd_reg(input pmd_reg_t r,
      input logic [35:0] a, input logic [35:0] b,
      input logic [15:0] vx0, input logic [15:0] vy0,
      input logic [15:0] vy1);
    logic [15:0] v;
    v = 16'h0000;
    case (r)
      PMD_R_X0: v = vx0;
      PMD_R_Y0: v = vy0;
      PMD_R_Y1: v = vy1;
      PMD_R_A1: v = a[31:16];
      PMD_R_B1: v = b[31:16];
      PMD_R_A0: v = a[15:0];
      PMD_R_B0: v = b[15:0];
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // RULE11: full accumulator limited to 16 bits
  function automatic logic [16:0] limit(input logic [35:0] acc);
    logic ext_used;
    ext_used = (acc[35:31] != 5'h00) && (acc[35:31] != 5'h1F);
    if (!ext_used) begin
      return {1'b0, acc[31:16]};
    end
    return {1'b1, acc[35] ? PMD_SAT_NEG : PMD_SAT_POS};
  endfunction

  function automatic logic is_acc_of(input pmd_reg_t r, input logic bsel);
    return bsel ? (r == PMD_R_B || r == PMD_R_B1 || r == PMD_R_B0)
                : (r == PMD_R_A || r == PMD_R_A1 || r == PMD_R_A0);
  endfunction

  wire go = instr_valid && (state_reg == PMD_S_IDLE);
  // RULE17: seventeen ops allow the single move
  wire op_par_ok = (instr.op >= PMD_OP_ADD) && (instr.op <= PMD_OP_NEG);
  // RULE8: dual read only on the listed ops
  wire op_dual_ok = (instr.op == PMD_OP_ADD) || (instr.op == PMD_OP_SUB) ||
    (instr.op == PMD_OP_MAC) || (instr.op == PMD_OP_MPY) ||
    (instr.op == PMD_OP_MACR) || (instr.op == PMD_OP_MPYR) ||
    (instr.op == PMD_OP_MOVE);
  wire is_par = (instr.mv == PMD_MV_SINGLE) || (instr.mv == PMD_MV_DUAL);
  wire test_like = (instr.op == PMD_OP_TST) || (instr.op == PMD_OP_CMP);
  // RULE20: test and compare may target their accumulator or its low word, not its high word
  wire dup_ok = test_like && (instr.mv_reg != (instr.dst_b ? PMD_R_B1
                                                          : PMD_R_A1));
  // RULE19: duplicate destination detection
  wire dup_dst = (instr.mv == PMD_MV_SINGLE) && !instr.mv_write &&
    op_par_ok && is_acc_of(instr.mv_reg, instr.dst_b) && !dup_ok;
  // RULE9: no parallel move on jump, lea, bit set
  wire par_bad = is_par && ((instr.mv == PMD_MV_SINGLE) ? !op_par_ok
                                                        : !op_dual_ok);
  // RULE21: reject illegal encoding
  wire reject = go && (dup_dst || par_bad);
  wire accept = go && !reject;

  // RULE18: alu source may also be move source
  wire [15:0] mv_src = rd_reg(instr.mv_reg, a_reg, b_reg,
                              x0_reg, y0_reg, y1_reg);
  wire [16:0] lim_a = limit(a_reg);
  wire [16:0] lim_b = limit(b_reg);
  // RULE12: word portions never limited
  wire [16:0] st_val = (instr.mv_reg == PMD_R_A) ? lim_a :
                       (instr.mv_reg == PMD_R_B) ? lim_b : {1'b0, mv_src};
  wire mv_load = accept && !instr.mv_write &&
    ((instr.mv == PMD_MV_SINGLE) || (instr.mv == PMD_MV_SHORT) ||
     (instr.mv == PMD_MV_IMM) || (instr.mv == PMD_MV_REG));
  wire mv_store = accept && instr.mv_write &&
    ((instr.mv == PMD_MV_SINGLE) || (instr.mv == PMD_MV_SHORT) ||
     (instr.mv == PMD_MV_IMM));
  // RULE5: load value from memory, immediate or register
  wire [15:0] ld_val = (instr.mv == PMD_MV_IMM) ? instr.imm :
                       (instr.mv == PMD_MV_REG) ? mv_src : mem_rdata;
  wire [15:0] rs_val = rd_reg(instr.src1, a_reg, b_reg,
                              x0_reg, y0_reg, y1_reg);
  // RULE6: conditional transfer only when true
  wire cond_go = accept && (instr.op == PMD_OP_COND) && instr.cond_true;
  // RULE14: sign extend and zero low word
  wire [35:0] ext_ld = {{4{ld_val[15]}}, ld_val, 16'h0000};
  wire [35:0] ext_rs = {{4{rs_val[15]}}, rs_val, 16'h0000};
  wire mac_start = accept && (instr.op == PMD_OP_SUMAC);
  // RULE4: short form confined to low 64 words
  wire [15:0] ea = (instr.mv == PMD_MV_SHORT) ?
                   {10'h000, instr.short_addr} : ptr_reg;
  wire [15:0] step = instr.mv_by_off ? off_reg : 16'h0001;
  wire [15:0] store_word = (instr.mv == PMD_MV_IMM) ? instr.imm
                                                     : st_val[15:0];
  wire sat_hit = mv_store && (instr.mv != PMD_MV_IMM) && st_val[16];

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PMD_S_IDLE: if (mac_start) begin
        state_next = PMD_S_MAC;
      end
      PMD_S_MAC: state_next = PMD_S_DONE;
      PMD_S_DONE: state_next = PMD_S_IDLE;
      default: state_next = PMD_S_IDLE;
    endcase
  end

  pmd_mac u_mac (
    .core_clk(core_clk),
    .rst(rst),
    .start(mac_start),
    .s1(rs_val),
    .s2(rd_reg(instr.src2, a_reg, b_reg, x0_reg, y0_reg, y1_reg)),
    // latched select: instr may change while the mac runs
    .acc_in(mac_b_reg ? b_reg : a_reg),
    .done(mac_done),
    .acc_out(mac_out)
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= PMD_S_IDLE;
      ptr_reg <= PMD_RST_WORD;
      off_reg <= PMD_RST_WORD;
      ill_reg <= 1'b0;
      mac_b_reg <= 1'b0;
      mem_reg <= '0;
    end else begin
      state_reg <= state_next;
      ill_reg <= reject;
      if (mac_start) begin
        mac_b_reg <= instr.dst_b;
      end
      // RULE10: peripherals sit in data space
      mem_reg.rd <= accept && !instr.mv_write &&
        ((instr.mv == PMD_MV_SINGLE) || (instr.mv == PMD_MV_SHORT) ||
         (instr.mv == PMD_MV_DUAL));
      mem_reg.wr <= mv_store;
      mem_reg.addr <= ea;
      mem_reg.wdata <= store_word;
      // RULE16: post-increment by one or offset
      if (accept && (instr.mv == PMD_MV_SINGLE || instr.mv == PMD_MV_DUAL)) begin
        ptr_reg <= ptr_reg + step;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lim_reg <= 1'b0;
    end else if (sat_hit) begin
      // RULE13: set wins over clear
      lim_reg <= 1'b1;
    end else if (limit_clear) begin
      lim_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      a_reg <= PMD_RST_ACC;
      b_reg <= PMD_RST_ACC;
    end else begin
      if (mac_done && !mac_b_reg) begin
        a_reg <= mac_out;
      end else if (mv_load && instr.mv_reg == PMD_R_A) begin
        a_reg <= ext_ld;
      end else if (mv_load && instr.mv_reg == PMD_R_A1) begin
        // RULE15: only the high word changes
        a_reg[31:16] <= ld_val;
      end else if (mv_load && instr.mv_reg == PMD_R_A0) begin
        a_reg[15:0] <= ld_val;
      end else if (cond_go && !instr.dst_b) begin
        a_reg <= ext_rs;
      end
      if (mac_done && mac_b_reg) begin
        b_reg <= mac_out;
      end else if (mv_load && instr.mv_reg == PMD_R_B) begin
        b_reg <= ext_ld;
      end else if (mv_load && instr.mv_reg == PMD_R_B1) begin
        b_reg[31:16] <= ld_val;
      end else if (mv_load && instr.mv_reg == PMD_R_B0) begin
        b_reg[15:0] <= ld_val;
      end else if (cond_go && instr.dst_b) begin
        b_reg <= ext_rs;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      x0_reg <= PMD_RST_WORD;
      y0_reg <= PMD_RST_WORD;
      y1_reg <= PMD_RST_WORD;
    end else if (accept && instr.mv == PMD_MV_DUAL) begin
      // RULE7: dual reads load registers only
      y0_reg <= mem_rdata;
      x0_reg <= mem_rdata2;
    end else if (mv_load) begin
      if (instr.mv_reg == PMD_R_X0) begin
        x0_reg <= ld_val;
      end
      if (instr.mv_reg == PMD_R_Y0) begin
        y0_reg <= ld_val;
      end
      if (instr.mv_reg == PMD_R_Y1) begin
        y1_reg <= ld_val;
      end
    end
  end

  assign mem_req = mem_reg;
  assign ptr_addr = ptr_reg;
  // mac holds the datapath for the two cycles after its start
  assign ready = (state_reg == PMD_S_IDLE);
  assign illegal = ill_reg;
  assign limit_flag = lim_reg;
  assign acc_a = a_reg;
  assign acc_b = b_reg;
  assign x0 = x0_reg;
  assign y0 = y0_reg;
  assign y1 = y1_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_limit_sticky: assert property (@(posedge core_clk) disable iff (rst)
    sat_hit |=> limit_flag) else $error("limit not set"); // RULE13
  a_limit_hold: assert property (@(posedge core_clk) disable iff (rst)
    limit_flag && !limit_clear |=> limit_flag)
    else $error("limit dropped"); // RULE13
  a_reject_dup: assert property (@(posedge core_clk) disable iff (rst)
    go && dup_dst |=> illegal && $stable(acc_a))
    else $error("duplicate not rejected"); // RULE21
  a_no_par_jump: assert property (@(posedge core_clk) disable iff (rst)
    go && is_par && instr.op == PMD_OP_JUMP |=> illegal)
    else $error("jump move accepted"); // RULE9
  a_mac_busy: assert property (@(posedge core_clk) disable iff (rst)
    mac_start |=> !ready ##1 !ready ##1 ready)
    else $error("mac timing wrong"); // RULE3
  a_short_range: assert property (@(posedge core_clk) disable iff (rst)
    accept && instr.mv == PMD_MV_SHORT |=>
    mem_req.addr < PMD_SHORT_WORDS) else $error("short out of range"); // RULE4
  a_cond_false: assert property (@(posedge core_clk) disable iff (rst)
    accept && instr.op == PMD_OP_COND && !instr.cond_true &&
    instr.mv == PMD_MV_NONE |=> $stable(acc_a) && $stable(acc_b))
    else $error("false transfer wrote"); // RULE6
  a_sign_ext: assert property (@(posedge core_clk) disable iff (rst)
    mv_load && instr.mv_reg == PMD_R_A && !mac_done |=>
    acc_a[15:0] == 16'h0000 && acc_a[35:32] == {4{acc_a[31]}})
    else $error("bad sign extension"); // RULE14
  c_mac: cover property (@(posedge core_clk) mac_start ##2 mac_done);
  c_sat: cover property (@(posedge core_clk) sat_hit);
  c_dual: cover property (@(posedge core_clk)
    accept && instr.mv == PMD_MV_DUAL);
  c_reject: cover property (@(posedge core_clk) reject);
endmodule // pmd_core

// ### verification/pmd_xmem_model.sv
`timescale 1ns/1ps
module pmd_xmem_model
  import pmd_pkg::*;
(
  core_clk,
  instr_valid,
  mem_req,
  ptr_addr,
  mem_rdata,
  mem_rdata2
);
  input wire logic core_clk;
  input wire logic instr_valid;
  input wire pmd_mem_t mem_req;
  input wire logic [15:0] ptr_addr;
  output logic [15:0] mem_rdata;
  output logic [15:0] mem_rdata2;
  // ----------------------------------------
  // word store
  // ----------------------------------------
  // low byte decode only; peripherals live in the same space
  logic [15:0] mem [0:255];
  logic [15:0] last_q = 16'h0000;
  wire [15:0] rd1_w = mem[ptr_addr[7:0]];
  wire [15:0] rd2_w = mem[{1'b1, ptr_addr[6:0]}];
  // peripherals as words
  // no request: show garbage, never the old word
  assign mem_rdata = instr_valid ? rd1_w : ~last_q;
  assign mem_rdata2 = instr_valid ? rd2_w : last_q ^ 16'h5A5A;
  always @(posedge core_clk) begin
    if (mem_req.wr) begin
      mem[mem_req.addr[7:0]] <= mem_req.wdata;
    end
    last_q <= mem_rdata;
  end
endmodule // pmd_xmem_model

// ### verification/test_parallel_move_datapath.sv
`timescale 1ns/1ps
module test_parallel_move_datapath;
  import pmd_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic limit_clear = 1'b0;
  pmd_instr_t instr = '0;
  pmd_mem_t mem_req;
  logic [15:0] mem_rdata, mem_rdata2, ptr_addr, x0, y0, y1;
  logic ready, illegal, limit_flag;
  logic [35:0] acc_a, acc_b;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;
  always #20 core_clk = ~core_clk;
  pmd_core dut_u (.core_clk(core_clk), .rst(rst), .instr_valid(instr_valid),
    .instr(instr), .mem_rdata(mem_rdata), .mem_rdata2(mem_rdata2),
    .limit_clear(limit_clear), .mem_req(mem_req), .ptr_addr(ptr_addr),
    .ready(ready), .illegal(illegal), .limit_flag(limit_flag),
    .acc_a(acc_a), .acc_b(acc_b), .x0(x0), .y0(y0), .y1(y1));
  pmd_xmem_model mem_u (.core_clk(core_clk), .instr_valid(instr_valid),
    .mem_req(mem_req), .ptr_addr(ptr_addr), .mem_rdata(mem_rdata),
    .mem_rdata2(mem_rdata2));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  function automatic logic [15:0] pat(input logic [7:0] i);
    return 16'h8421 ^ {i, ~i};
  endfunction
  function automatic logic [35:0] ld(input logic [15:0] d);
    return {{4{d[15]}}, d, 16'h0000};
  endfunction
  function automatic pmd_instr_t mk(pmd_op_t op, pmd_mv_t mv, pmd_reg_t r,
      logic w);
    pmd_instr_t i;
    i = '0;
    i.op = op;
    i.mv = mv;
    i.mv_reg = r;
    i.mv_write = w;
    i.src1 = PMD_R_X0;
    i.src2 = PMD_R_NONE;
    return i;
  endfunction
  // returns at the falling edge of the answer cycle
  task automatic issue(input pmd_instr_t i);
    @(negedge core_clk);
    instr_valid = 1'b1;
    instr = i;
    @(negedge core_clk);
    instr_valid = 1'b0;
  endtask
  task automatic load(input pmd_reg_t r, input logic [15:0] v);
    pmd_instr_t i;
    i = mk(PMD_OP_MOVE, PMD_MV_IMM, r, 1'b0);
    i.imm = v;
    issue(i);
  endtask
  task automatic clear_limit();
    @(negedge core_clk);
    limit_clear = 1'b1;
    @(negedge core_clk);
    limit_clear = 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk({acc_a, acc_b}, '0);
    chk({x0, y0, y1, ptr_addr}, '0);
    chk({ready, illegal, limit_flag}, 3'h4);
  endtask
  task automatic t_loads();
    load(PMD_R_A, 16'h8001);
    chk(acc_a, 36'hF80010000);
    load(PMD_R_A1, 16'h1234);
    chk(acc_a, 36'hF12340000);
    load(PMD_R_B, 16'h7FFF);
    chk(acc_b, 36'h07FFF0000);
    load(PMD_R_Y1, 16'hBEEF);
    chk(y1, 16'hBEEF);
  endtask
  task automatic t_mac(input logic [15:0] a, input logic [15:0] b,
      input logic [15:0] init);
    pmd_instr_t i;
    logic [35:0] e;
    logic [35:0] p;
    logic [15:0] p0;
    logic sat;
    // product is 32 bits wide, then sign extended into the sum
    p = ($signed({{20{a[15]}}, a}) * $signed({20'h00000, b})) <<< 1;
    e = ld(init) + {{4{p[31]}}, p[31:0]};
    sat = (e[35:31] != 5'h00) && (e[35:31] != 5'h1F);
    load(PMD_R_A, init);
    load(PMD_R_X0, a);
    load(PMD_R_Y0, b);
    clear_limit();
    i = mk(PMD_OP_SUMAC, PMD_MV_NONE, PMD_R_NONE, 1'b0);
    i.src2 = PMD_R_Y0;
    issue(i);
    chk(ready, 1'b0);
    @(negedge core_clk);
    chk({ready, acc_a}, {1'b0, ld(init)});
    @(negedge core_clk);
    chk({ready, acc_a}, {1'b1, e});
    p0 = ptr_addr;
    issue(mk(PMD_OP_TST, PMD_MV_SINGLE, PMD_R_A, 1'b1));
    chk({mem_req.wr, mem_req.addr}, {1'b1, p0});
    chk(ptr_addr, p0 + 16'h0001);
    chk(mem_req.wdata, !sat ? e[31:16] : e[35] ? PMD_SAT_NEG : PMD_SAT_POS);
    chk(limit_flag, sat);
    @(negedge core_clk);
    chk({mem_req.wr, limit_flag}, {1'b0, sat});
    clear_limit();
    issue(mk(PMD_OP_TST, PMD_MV_SINGLE, PMD_R_A1, 1'b1));
    chk({mem_req.wdata, limit_flag}, {e[31:16], 1'b0});
  endtask
  task automatic t_illegal();
    pmd_instr_t bad [8];
    logic [35:0] a0;
    logic [15:0] p0;
    bad[0] = mk(PMD_OP_JUMP, PMD_MV_SINGLE, PMD_R_X0, 1'b0);
    bad[1] = mk(PMD_OP_LEA, PMD_MV_SINGLE, PMD_R_X0, 1'b0);
    bad[2] = mk(PMD_OP_BIT_FIELD_SET_OP, PMD_MV_SINGLE, PMD_R_X0, 1'b0);
    bad[3] = mk(PMD_OP_COND, PMD_MV_SINGLE, PMD_R_X0, 1'b0);
    bad[4] = mk(PMD_OP_SUMAC, PMD_MV_SINGLE, PMD_R_X0, 1'b0);
    bad[5] = mk(PMD_OP_TST, PMD_MV_DUAL, PMD_R_Y0, 1'b0);
    // only ever sent to be refused
    bad[6] = mk(PMD_OP_ADD, PMD_MV_SINGLE, PMD_R_A, 1'b0);
    bad[7] = mk(PMD_OP_ASL, PMD_MV_SINGLE, PMD_R_A1, 1'b0);
    for (int k = 0; k < 8; k++) begin
      a0 = acc_a;
      p0 = ptr_addr;
      issue(bad[k]);
      chk(illegal, 1'b1);
      chk({acc_a, ptr_addr}, {a0, p0});
      chk({mem_req.rd, mem_req.wr}, 2'h0);
    end
  endtask
  task automatic t_legal();
    pmd_instr_t i;
    logic [15:0] d;
    d = pat(ptr_addr[7:0]);
    issue(mk(PMD_OP_TST, PMD_MV_SINGLE, PMD_R_A, 1'b0));
    chk({illegal, acc_a}, {1'b0, ld(d)});
    d = pat(ptr_addr[7:0]);
    issue(mk(PMD_OP_CMP, PMD_MV_SINGLE, PMD_R_A0, 1'b0));
    chk({illegal, acc_a[15:0]}, {1'b0, d});
    i = mk(PMD_OP_ADD, PMD_MV_SINGLE, PMD_R_A, 1'b1);
    i.src1 = PMD_R_A;
    i.dst_b = 1'b1;
    d = acc_a[31:16];
    issue(i);
    chk({illegal, mem_req.wdata}, {1'b0, d});
  endtask
  task automatic t_dual();
    logic [35:0] a0;
    logic [15:0] p0;
    a0 = acc_a;
    p0 = ptr_addr;
    issue(mk(PMD_OP_MOVE, PMD_MV_DUAL, PMD_R_Y0, 1'b0));
    chk({y0, x0}, {pat(p0[7:0]), pat({1'b1, p0[6:0]})});
    chk({acc_a, ptr_addr}, {a0, p0 + 16'h0001});
  endtask
  task automatic t_cond();
    pmd_instr_t i;
    logic [35:0] a0;
    load(PMD_R_X0, 16'h2468);
    load(PMD_R_Y1, 16'h0000);
    a0 = acc_a;
    i = mk(PMD_OP_COND, PMD_MV_NONE, PMD_R_Y1, 1'b0);
    issue(i);
    chk(acc_a, a0);
    i.cond_true = 1'b1;
    issue(i);
    chk(acc_a, ld(16'h2468));
  endtask
  task automatic t_short();
    pmd_instr_t i;
    load(PMD_R_X0, 16'h5AC3);
    i = mk(PMD_OP_MOVE, PMD_MV_SHORT, PMD_R_X0, 1'b1);
    i.short_addr = 6'h3F;
    issue(i);
    chk({mem_req.wr, mem_req.addr}, {1'b1, 16'h003F});
    chk(mem_req.wdata, 16'h5AC3);
  endtask
  // budget: whole sequence is about 140 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    for (int k = 0; k < 256; k++) begin
      mem_u.mem[k] = pat(8'(k));
    end
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    t_reset();
    t_loads();
    t_mac(16'h3456, 16'h8000, 16'h0000);
    t_mac(16'h7FFF, 16'hFFFF, 16'h0000);
    t_mac(16'h8000, 16'hFFFF, 16'h0000);
    t_mac(16'h3456, 16'h8000, 16'h7FFF);
    t_illegal();
    t_legal();
    t_dual();
    t_cond();
    t_short();
    wrap_up();
  end
endmodule // test_parallel_move_datapath
